// File: hdl/mpu_external_bus_interface.sv
// What this block does
// - drive 20-bit address; memory spans 1 MB, I/O spans 64 KB.
// - address outputs float during reset and while bus is granted away; bit 18 stays driven in grant when timer output is selected.
// - 8-bit data bus floats during reset and bus grant.
// - address bit 18 shared with timer pulse; address function after reset.
// - bus hold request beats nmi, taken at cycle end, floats bus.
// - assert bus hold grant low while bus and strobes float.
// - wait sampled at falling clock of T2 and waits; low adds waits.
// - irq zero served at instruction end if nmi and hold idle; marker+io.
// - irq one served if nmi, hold, irq zero idle; irq two also needs irq one idle; no marker, no io.
// - nmi falling-edge detected, outranks irqs, ignores enables, vector 0066h.
// - io strobe low while address holds valid I/O address.
// - memory strobe low while address holds valid memory address.
// - marker with memory strobe is fetch; with io strobe is acknowledge.
// - status/halt/marker 010 first fetch, 110 later fetch and irq zero acknowledge, 111 other.
// - status/halt/marker 0X1 dma, 000 halt, 101 sleep.
// - halt output low while waiting after halt or sleep.
// - read strobe low when data wanted; far side gates data with it.
// - write strobe low while data bus holds valid write data.
// - refresh strobe with memory strobe; low 8 address bits refresh address.
// - system clock output at half the input clock.
// - dma requests active low, each level or edge sensed.
// - transfer done low during final dma write cycle.
`timescale 1ns/1ns
`default_nettype none
module mpu_external_bus_interface
  import bus_if_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // core machine cycle request
  input  wire logic              i_cyc_valid,
  input  wire logic [3:0]        i_cyc_kind,
  input  wire logic [ADDR_W-1:0] i_cyc_addr,
  input  wire logic [DATA_W-1:0] i_cyc_wdata,
  input  wire logic              i_cyc_dma_chan,
  input  wire logic              i_cyc_last,
  output logic                   o_cyc_ready,
  output logic                   o_cyc_done,
  output logic [DATA_W-1:0]      o_cyc_rdata,
  // core mode and interrupt service
  input  wire logic              i_halt_mode,
  input  wire logic              i_sleep_mode,
  input  wire logic              i_instr_end,
  input  wire logic [2:0]        i_int_enable,
  input  wire logic              i_nmi_taken,
  output logic                   o_take_nmi,
  output logic [2:0]             o_take_irq,
  // timer and dma sideband
  input  wire logic              i_timer_out_select,
  input  wire logic              i_timer_pulse,
  input  wire logic [1:0]        i_dma_edge_mode,
  output logic [1:0]             o_dma_request,
  // address and data pins
  output logic [ADDR_W-1:0]      o_address,
  output logic [ADDR_W-1:0]      o_address_oe_n,
  output logic [DATA_W-1:0]      o_data_out,
  output logic                   o_data_oe_n,
  input  wire logic [DATA_W-1:0] i_data_in,
  // strobe and status pins
  output logic                   o_memory_strobe_n,
  output logic                   o_io_strobe_n,
  output logic                   o_read_strobe_n,
  output logic                   o_write_strobe_n,
  output logic                   o_strobe_oe_n,
  output logic                   o_refresh_strobe_n,
  output logic                   o_first_cycle_marker_n,
  output logic                   o_cycle_status_out,
  output logic                   o_halt_n,
  output logic                   o_transfer_done_zero_n,
  output logic                   o_transfer_done_one_n,
  output logic                   o_system_clock_out,
  // system control pins
  output logic                   o_bus_hold_grant_n,
  input  wire logic              i_bus_hold_request_n,
  input  wire logic              i_wait_n,
  input  wire logic              i_nmi_n,
  input  wire logic              i_irq_line_zero_n,
  input  wire logic              i_irq_line_one_n,
  input  wire logic              i_irq_line_two_n,
  input  wire logic              i_dma_request_zero_n,
  input  wire logic              i_dma_request_one_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_io(input logic [3:0] k);
    is_io = (k == K_IO_RD) || (k == K_IO_WR) || (k == K_DMA_IO_RD) || (k == K_DMA_IO_WR);
  endfunction

  function automatic logic is_wr(input logic [3:0] k);
    is_wr = (k == K_MEM_WR) || (k == K_IO_WR) || (k == K_DMA_MEM_WR) || (k == K_DMA_IO_WR);
  endfunction

  function automatic logic is_dma(input logic [3:0] k);
    is_dma = (k >= K_DMA_MEM_RD) && (k <= K_DMA_IO_WR);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bus_state_e          state, next_state;
  logic                sys_clk, next_sys_clk;
  logic [SYNC_W-1:0]   meta, sync, sync_prev;
  logic [DATA_W-1:0]   dmeta, dsync;
  logic [3:0]          kind, next_kind;
  logic [ADDR_W-1:0]   addr, next_addr;
  logic [DATA_W-1:0]   wdata, next_wdata;
  logic                dchan, next_dchan;
  logic                last, next_last;
  logic                wait_seen, next_wait_seen;
  logic                nmi_pend, next_nmi_pend;
  logic                in_cyc, act, wr_win, hold_req;
  logic [2:0]          stat;

  assign hold_req    = ~sync[SY_HOLD];
  // a cycle starts only at a T-state boundary and never against a hold request
  assign o_cyc_ready = (state == S_IDLE) && !sys_clk && !hold_req;
  assign in_cyc      = (state == S_T1) || (state == S_T2) || (state == S_TW) || (state == S_T3);
  // address goes valid in T1 high half, strobes from the T1 falling edge
  assign act         = ((state == S_T1) && !sys_clk) || (state == S_T2)
                       || (state == S_TW) || (state == S_T3);
  assign wr_win      = (state == S_T2) || (state == S_TW) || ((state == S_T3) && sys_clk);

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    next_sys_clk   = ~sys_clk;
    next_state     = state;
    next_kind      = kind;
    next_addr      = addr;
    next_wdata     = wdata;
    next_dchan     = dchan;
    next_last      = last;
    next_wait_seen = wait_seen;
    // set wins over the core's clear
    next_nmi_pend  = (nmi_pend && !i_nmi_taken)
                     || (sync_prev[SY_NMI] && !sync[SY_NMI]);
    if (state == S_T2 || state == S_TW) begin
      if (sys_clk) begin
        next_wait_seen = ~sync[SY_WAIT];
      end
    end
    case (state)
      S_IDLE: begin
        if (!sys_clk && hold_req) begin
          next_state = S_HOLD;
        end else if (o_cyc_ready && i_cyc_valid) begin
          next_state = S_T1;
          next_kind  = i_cyc_kind;
          next_wdata = i_cyc_wdata;
          next_dchan = i_cyc_dma_chan;
          next_last  = i_cyc_last;
          if (i_cyc_kind == K_REFRESH) begin
            next_addr = i_cyc_addr & REFRESH_STROBE_N_ADDR_MASK;
          end else if (is_io(i_cyc_kind)) begin
            next_addr = i_cyc_addr & IO_ADDR_MASK;
          end else begin
            next_addr = i_cyc_addr;
          end
        end
      end
      S_T1:    next_state = sys_clk ? S_T1 : S_T2;
      S_T2, S_TW: begin
        if (!sys_clk) begin
          next_state = wait_seen ? S_TW : S_T3;
        end
      end
      S_T3:    next_state = sys_clk ? S_T3 : S_IDLE;
      S_HOLD:  next_state = (!sys_clk && !hold_req) ? S_IDLE : S_HOLD;
      default: next_state = S_IDLE;
    endcase
    // status triple {status, halt, marker}
    if (in_cyc) begin
      case (kind)
        K_FETCH1: stat = 3'b010;
        K_FETCH2: stat = 3'b110;
        K_ACK0:   stat = 3'b110;
        default:  stat = is_dma(kind) ? 3'b011 : 3'b111;
      endcase
    end else if (state == S_HOLD) begin
      stat = 3'b111;
    end else if (i_halt_mode) begin
      stat = 3'b000;
    end else if (i_sleep_mode) begin
      stat = 3'b101;
    end else begin
      stat = 3'b111;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state                  <= S_IDLE;
      sys_clk                <= 1'b0;
      meta                   <= SYNC_IDLE;
      sync                   <= SYNC_IDLE;
      sync_prev              <= SYNC_IDLE;
      dmeta                  <= DATA_RESET;
      dsync                  <= DATA_RESET;
      kind                   <= K_MEM_RD;
      addr                   <= ADDR_RESET;
      wdata                  <= DATA_RESET;
      dchan                  <= 1'b0;
      last                   <= 1'b0;
      wait_seen              <= 1'b0;
      nmi_pend               <= 1'b0;
      o_cyc_done             <= 1'b0;
      o_cyc_rdata            <= DATA_RESET;
      o_take_nmi             <= 1'b0;
      o_take_irq             <= 3'b000;
      o_dma_request          <= 2'b00;
      o_address              <= ADDR_RESET;
      o_address_oe_n         <= '1;
      o_data_out             <= DATA_RESET;
      o_data_oe_n            <= 1'b1;
      o_memory_strobe_n      <= 1'b1;
      o_io_strobe_n          <= 1'b1;
      o_read_strobe_n        <= 1'b1;
      o_write_strobe_n       <= 1'b1;
      o_strobe_oe_n          <= 1'b0;
      o_refresh_strobe_n     <= 1'b1;
      o_first_cycle_marker_n <= 1'b1;
      o_cycle_status_out     <= 1'b1;
      o_halt_n               <= 1'b1;
      o_transfer_done_zero_n <= 1'b1;
      o_transfer_done_one_n  <= 1'b1;
      o_system_clock_out     <= 1'b0;
      o_bus_hold_grant_n     <= 1'b1;
    end else begin
      state      <= next_state;
      sys_clk    <= next_sys_clk;
      meta       <= {i_dma_request_one_n, i_dma_request_zero_n, i_irq_line_two_n,
                     i_irq_line_one_n, i_irq_line_zero_n, i_nmi_n, i_wait_n,
                     i_bus_hold_request_n};
      sync       <= meta;
      sync_prev  <= sync;
      dmeta      <= i_data_in;
      dsync      <= dmeta;
      kind       <= next_kind;
      addr       <= next_addr;
      wdata      <= next_wdata;
      dchan      <= next_dchan;
      last       <= next_last;
      wait_seen  <= next_wait_seen;
      nmi_pend   <= next_nmi_pend;
      o_cyc_done <= (state == S_T3) && !sys_clk;
      if ((state == S_T3) && !sys_clk && !is_wr(kind)) begin
        o_cyc_rdata <= dsync;
      end
      // hold request outranks nmi, nmi outranks the maskable lines
      o_take_nmi    <= i_instr_end && !hold_req && nmi_pend;
      o_take_irq[0] <= i_instr_end && !hold_req && !nmi_pend
                       && i_int_enable[0] && !sync[SY_IRQ0];
      o_take_irq[1] <= i_instr_end && !hold_req && !nmi_pend && !(i_int_enable[0]
                       && !sync[SY_IRQ0]) && i_int_enable[1] && !sync[SY_IRQ1];
      o_take_irq[2] <= i_instr_end && !hold_req && !nmi_pend && !(i_int_enable[0]
                       && !sync[SY_IRQ0]) && !(i_int_enable[1] && !sync[SY_IRQ1])
                       && i_int_enable[2] && !sync[SY_IRQ2];
      // edge mode reports one pulse per falling edge, level mode follows the pin
      o_dma_request[0] <= i_dma_edge_mode[0] ? (sync_prev[SY_DMA_REQUEST_ZERO_N] && !sync[SY_DMA_REQUEST_ZERO_N])
                                             : !sync[SY_DMA_REQUEST_ZERO_N];
      o_dma_request[1] <= i_dma_edge_mode[1] ? (sync_prev[SY_DMA_REQUEST_ONE_N] && !sync[SY_DMA_REQUEST_ONE_N])
                                             : !sync[SY_DMA_REQUEST_ONE_N];
      o_address   <= addr;
      o_address[ADDR_BIT_18] <= i_timer_out_select ? i_timer_pulse : addr[ADDR_BIT_18];
      o_address_oe_n <= {ADDR_W{state == S_HOLD}};
      o_address_oe_n[ADDR_BIT_18] <= (state == S_HOLD) && !i_timer_out_select;
      o_data_out  <= wdata;
      o_data_oe_n <= !(act && is_wr(kind));
      o_memory_strobe_n <= !(act && !is_io(kind) && kind != K_ACK0
                             && kind != K_ACK12);
      o_io_strobe_n     <= !(act && (is_io(kind) || kind == K_ACK0));
      o_read_strobe_n   <= !(act && !is_wr(kind) && kind != K_REFRESH
                             && kind != K_ACK12);
      o_write_strobe_n  <= !(wr_win && is_wr(kind));
      o_strobe_oe_n     <= (state == S_HOLD);
      o_refresh_strobe_n <= !(act && kind == K_REFRESH);
      o_first_cycle_marker_n <= stat[0];
      o_cycle_status_out     <= stat[2];
      o_halt_n               <= stat[1];
      o_transfer_done_zero_n <= !(in_cyc && is_dma(kind) && is_wr(kind)
                                  && last && !dchan);
      o_transfer_done_one_n  <= !(in_cyc && is_dma(kind) && is_wr(kind)
                                  && last && dchan);
      o_system_clock_out <= next_sys_clk;
      // grant leaves the same register stage as the enables, so the other
      // master never sees it while data, strobes or any address bit but a timer-selected bit 18 are still driven
      o_bus_hold_grant_n <= !(state == S_HOLD);
    end
  end

endmodule // mpu_external_bus_interface
`default_nettype wire

// File: hdl/bus_if_pkg.sv
package bus_if_pkg;

  // ----------------------------------------------------------------
  // widths and constants
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 20;
  localparam int          DATA_W        = 8;
  localparam int          SYNC_W        = 8;
  localparam int          REFRESH_W     = 8;
  localparam int          ADDR_BIT_18   = 18;
  localparam logic [19:0] NMI_VECTOR    = 20'h0_0066;
  localparam logic [19:0] IO_ADDR_MASK  = 20'h0_FFFF;
  localparam logic [19:0] REFRESH_STROBE_N_ADDR_MASK = 20'h0_00FF;
  localparam logic [19:0] ADDR_RESET    = 20'h0_0000;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [7:0]  SYNC_IDLE     = 8'hFF;

  // positions inside the synchronised input vector
  localparam int SY_HOLD  = 0;
  localparam int SY_WAIT  = 1;
  localparam int SY_NMI   = 2;
  localparam int SY_IRQ0  = 3;
  localparam int SY_IRQ1  = 4;
  localparam int SY_IRQ2  = 5;
  localparam int SY_DMA_REQUEST_ZERO_N = 6;
  localparam int SY_DMA_REQUEST_ONE_N = 7;

  // ----------------------------------------------------------------
  // machine cycle kinds and bus states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    K_FETCH1     = 4'h0,
    K_FETCH2     = 4'h1,
    K_MEM_RD     = 4'h2,
    K_MEM_WR     = 4'h3,
    K_IO_RD      = 4'h4,
    K_IO_WR      = 4'h5,
    K_ACK0       = 4'h6,
    K_ACK12      = 4'h7,
    K_REFRESH    = 4'h8,
    K_DMA_MEM_RD = 4'h9,
    K_DMA_MEM_WR = 4'hA,
    K_DMA_IO_RD  = 4'hB,
    K_DMA_IO_WR  = 4'hC
  } cyc_kind_e;

  // gray codes along idle -> t1 -> t2 -> tw -> t3 -> hold
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_T1   = 3'b001,
    S_T2   = 3'b011,
    S_TW   = 3'b010,
    S_T3   = 3'b110,
    S_HOLD = 3'b100
  } bus_state_e;

endpackage

// File: tb/bus_if_checker.sv
`timescale 1ns/1ns
`default_nettype none
module bus_if_checker
  import bus_if_pkg::*;
(
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_rst,
  // core side
  input wire logic              i_cyc_valid,
  input wire logic              o_cyc_ready,
  input wire logic              o_cyc_done,
  input wire logic              i_instr_end,
  input wire logic              o_take_nmi,
  input wire logic [2:0]        o_take_irq,
  // pins
  input wire logic [ADDR_W-1:0] o_address,
  input wire logic [ADDR_W-1:0] o_address_oe_n,
  input wire logic              o_data_oe_n,
  input wire logic              o_memory_strobe_n,
  input wire logic              o_io_strobe_n,
  input wire logic              o_read_strobe_n,
  input wire logic              o_write_strobe_n,
  input wire logic              o_strobe_oe_n,
  input wire logic              o_refresh_strobe_n,
  input wire logic              o_first_cycle_marker_n,
  input wire logic              o_cycle_status_out,
  input wire logic              o_halt_n,
  input wire logic              o_system_clock_out,
  input wire logic              o_bus_hold_grant_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence take_s; i_cyc_valid && o_cyc_ready; endsequence
  sequence done_s; ##[7:300] o_cyc_done; endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  cycle_done_a: assert property (take_s |-> done_s)
    else $error("cycle never completed");
  done_pulse_a: assert property (o_cyc_done |=> !o_cyc_done)
    else $error("done longer than one cycle");
  // reset is checked while it is held, so the default disable is overridden
  reset_float_a: assert property (disable iff (1'b0) i_rst |-> &o_address_oe_n && o_data_oe_n)
    else $error("bus driven in reset");
  grant_float_a: assert property (!o_bus_hold_grant_n |->
    &o_address_oe_n[17:0] && o_address_oe_n[19] && o_data_oe_n && o_strobe_oe_n)
    else $error("bus driven while granted");
  io_space_a: assert property (!o_io_strobe_n && o_first_cycle_marker_n |->
    o_address[19:16] == 4'h0)
    else $error("io address above 64k");
  refresh_mem_a: assert property (!o_refresh_strobe_n |->
    !o_memory_strobe_n && o_address[19:8] == 12'h000)
    else $error("bad refresh cycle");
  fetch_status_a: assert property (!o_first_cycle_marker_n && !o_memory_strobe_n |-> o_halt_n)
    else $error("bad fetch status");
  ack_status_a: assert property (!o_first_cycle_marker_n && !o_io_strobe_n |->
    o_cycle_status_out && o_halt_n)
    else $error("bad acknowledge status");
  halt_status_a: assert property (!o_halt_n |-> o_cycle_status_out == o_first_cycle_marker_n)
    else $error("bad halt or sleep status");
  clock_half_a: assert property (1'b1 |=> $changed(o_system_clock_out))
    else $error("system clock not halved");
  read_dir_a: assert property (!o_read_strobe_n |-> o_write_strobe_n && o_data_oe_n)
    else $error("data driven during read");
  write_data_a: assert property (!o_write_strobe_n |-> !o_data_oe_n)
    else $error("write without data");
  irq_order_a: assert property ((o_take_nmi || |o_take_irq) |->
    $past(i_instr_end) && $onehot({o_take_nmi, o_take_irq}))
    else $error("bad interrupt take");
endmodule // bus_if_checker
`default_nettype wire

// File: tb/far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module far_side_model
  import bus_if_pkg::*;
(
  // clock and bench control
  input  wire logic              i_clk,
  input  wire logic              i_clear,
  input  wire logic [3:0]        i_waits,
  // pins from the device
  input  wire logic [ADDR_W-1:0] i_address,
  input  wire logic [DATA_W-1:0] i_data_out,
  input  wire logic              i_data_oe_n,
  input  wire logic [8:0]        i_strobes_n,
  // pins to the device
  output logic [DATA_W-1:0]      o_data_in,
  output logic                   o_wait_n,
  // what the last cycle looked like
  output logic [8:0]             o_seen,
  output logic [ADDR_W-1:0]      o_seen_addr,
  output logic [DATA_W-1:0]      o_seen_wdata
);
  logic [3:0] busy;
  logic [7:0] last_drv;
  logic       sel;
  assign sel = !(i_strobes_n[8] && i_strobes_n[7]);
  // a slow device holds wait low until selected long enough
  assign o_wait_n = (busy >= i_waits);
  // data only while gated by read; otherwise the inverse of the last byte
  assign o_data_in = !i_strobes_n[6] ? i_address[7:0] ^ i_address[15:8] ^
                     {i_address[19:16], i_address[19:16]} : ~last_drv;
  always_ff @(posedge i_clk) begin
    if (!i_strobes_n[6]) last_drv <= o_data_in;
    if (i_clear) begin
      o_seen <= 9'h000;
      busy   <= 4'h0;
    end else begin
      o_seen <= o_seen | ~i_strobes_n;
      if (sel && busy != 4'hf) busy <= busy + 4'h1;
      if (sel) o_seen_addr <= i_address;
      if (!i_strobes_n[5] && !i_data_oe_n) o_seen_wdata <= i_data_out;
    end
  end
endmodule // far_side_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import bus_if_pkg::*;
  logic i_clk = 0, i_rst = 0, i_cyc_valid = 0, i_cyc_dma_chan = 0, i_cyc_last = 0, clr = 1;
  logic i_halt_mode = 0, i_sleep_mode = 0, i_instr_end = 0, i_nmi_taken = 0, i_timer_pulse = 0;
  logic i_timer_out_select = 0, i_bus_hold_request_n = 1, i_nmi_n = 1, i_wait_n;
  logic i_irq_line_zero_n = 1, i_irq_line_one_n = 1, i_irq_line_two_n = 1;
  logic i_dma_request_zero_n = 1, i_dma_request_one_n = 1;
  logic [3:0] i_cyc_kind = 0, waits = 0;
  logic [2:0] i_int_enable = 0, o_take_irq;
  logic [1:0] i_dma_edge_mode = 0, o_dma_request;
  logic [ADDR_W-1:0] i_cyc_addr = 0, o_address, o_address_oe_n, seen_addr;
  logic [DATA_W-1:0] i_cyc_wdata = 0, i_data_in, o_data_out, o_cyc_rdata, seen_wdata;
  logic [8:0] seen;
  logic o_cyc_ready, o_cyc_done, o_take_nmi, o_data_oe_n, o_memory_strobe_n, o_io_strobe_n;
  logic o_read_strobe_n, o_write_strobe_n, o_strobe_oe_n, o_refresh_strobe_n, o_halt_n;
  logic o_first_cycle_marker_n, o_cycle_status_out, o_transfer_done_zero_n;
  logic o_transfer_done_one_n, o_system_clock_out, o_bus_hold_grant_n;
  int num_errors = 0, num_checks = 0, cycles = 0;
  mpu_external_bus_interface i_dut (.i_clk, .i_rst, .i_cyc_valid, .i_cyc_kind, .i_cyc_addr,
    .i_cyc_wdata, .i_cyc_dma_chan, .i_cyc_last, .o_cyc_ready, .o_cyc_done, .o_cyc_rdata,
    .i_halt_mode, .i_sleep_mode, .i_instr_end, .i_int_enable, .i_nmi_taken, .o_take_nmi,
    .o_take_irq, .i_timer_out_select, .i_timer_pulse, .i_dma_edge_mode, .o_dma_request,
    .o_address, .o_address_oe_n, .o_data_out, .o_data_oe_n, .i_data_in, .o_memory_strobe_n,
    .o_io_strobe_n, .o_read_strobe_n, .o_write_strobe_n, .o_strobe_oe_n, .o_refresh_strobe_n,
    .o_first_cycle_marker_n, .o_cycle_status_out, .o_halt_n, .o_transfer_done_zero_n,
    .o_transfer_done_one_n, .o_system_clock_out, .o_bus_hold_grant_n, .i_bus_hold_request_n,
    .i_wait_n, .i_nmi_n, .i_irq_line_zero_n, .i_irq_line_one_n, .i_irq_line_two_n,
    .i_dma_request_zero_n, .i_dma_request_one_n);
  far_side_model i_far (.i_clk, .i_clear(clr), .i_waits(waits), .i_address(o_address),
    .i_data_out(o_data_out), .i_data_oe_n(o_data_oe_n), .i_strobes_n({o_memory_strobe_n,
    o_io_strobe_n, o_read_strobe_n, o_write_strobe_n, o_refresh_strobe_n,
    o_first_cycle_marker_n, o_cycle_status_out, o_transfer_done_zero_n,
    o_transfer_done_one_n}), .o_data_in(i_data_in), .o_wait_n(i_wait_n), .o_seen(seen),
    .o_seen_addr(seen_addr), .o_seen_wdata(seen_wdata));
  always #2 i_clk = ~i_clk;
  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // flags seen low: mem io rd wr refresh_strobe_n marker status td0 td1
  function automatic logic [8:0] exp_flags(input logic [3:0] k, input logic [1:0] td);
    case (k)
      K_FETCH1: return 9'h14c;
      K_FETCH2: return 9'h148;
      K_MEM_RD: return 9'h140;
      K_MEM_WR: return 9'h120;
      K_IO_RD: return 9'h0c0;
      K_IO_WR: return 9'h0a0;
      K_ACK0: return 9'h088;
      K_REFRESH: return 9'h110;
      K_DMA_MEM_RD: return 9'h144;
      K_DMA_MEM_WR: return {7'h49, td};
      K_DMA_IO_RD: return 9'h0c4;
      K_DMA_IO_WR: return {7'h29, td};
      default: return 9'h000;
    endcase
  endfunction
  task automatic run_cycle(input logic [3:0] k, input logic [19:0] a, input logic [7:0] d,
                           input logic ch, input logic lst, input logic [3:0] w);
    logic [8:0]  f;
    logic [19:0] ea;
    int          n;
    lst = lst && (k == K_DMA_MEM_WR || k == K_DMA_IO_WR);
    f = exp_flags(k, {lst && !ch, lst && ch});
    ea = (k inside {K_IO_RD, K_IO_WR, K_DMA_IO_RD, K_DMA_IO_WR}) ? a & IO_ADDR_MASK :
         (k == K_REFRESH) ? a & REFRESH_STROBE_N_ADDR_MASK : a;
    clr = 1;
    // nothing is addressed in this acknowledge, so no device may pull wait low
    waits = (k == K_ACK12) ? 4'h0 : w;
    @(posedge i_clk) #1;
    clr = 0;
    i_timer_pulse = 1'($urandom);
    {i_cyc_valid, i_cyc_kind, i_cyc_addr, i_cyc_wdata, i_cyc_dma_chan, i_cyc_last} =
      {1'b1, k, a, d, ch, lst};
    n = 0;
    do begin @(negedge i_clk); n++; end while (o_cyc_ready !== 1'b1 && n < 50);
    @(posedge i_clk) #1;
    i_cyc_valid = 0;
    n = 0;
    do begin @(negedge i_clk); n++; end while (o_cyc_done !== 1'b1 && n < 300);
    check("latency", (waits == 0) ? (n == 7 || n == 8) : (n > 8 && n < 300), 1);
    check("strobes", seen & ((k inside {K_ACK0, K_ACK12, K_REFRESH}) ? 9'h1bf : 9'h1ff), f);
    if (k != K_ACK0 && k != K_ACK12) check("address", seen_addr, ea);
    if (f[5]) check("write data", seen_wdata, d);
    if (f[6]) check("read data", o_cyc_rdata, ea[7:0] ^ ea[15:8] ^ {2{ea[19:16]}});
  endtask
  task automatic irq_case(input logic [2:0] lines_n, input logic [2:0] en, input logic nmi);
    logic [3:0] e;
    logic [2:0] r;
    r = ~lines_n & en;
    e = nmi ? 4'h8 : r[0] ? 4'h1 : r[1] ? 4'h2 : r[2] ? 4'h4 : 4'h0;
    @(posedge i_clk) #1;
    {i_irq_line_two_n, i_irq_line_one_n, i_irq_line_zero_n} = lines_n;
    i_int_enable = en;
    i_nmi_n = !nmi;
    repeat (4) @(posedge i_clk);
    #1 i_instr_end = 1;
    @(posedge i_clk) #1;
    i_instr_end = 0;
    check("take", {o_take_nmi, o_take_irq}, i_bus_hold_request_n ? e : 4'h0);
    i_nmi_taken = nmi;
    i_nmi_n = 1;
    @(posedge i_clk) #1;
    i_nmi_taken = 0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    n = $urandom(32'h0000_7b27);
    // raise reset off the clock edge so the first edge already sees it
    #1 i_rst = 1;
    repeat (10) @(posedge i_clk);
    check("reset float", {o_address_oe_n, o_data_oe_n}, 21'h1f_ffff);
    #1 i_rst = 0;
    // first pass walks every kind without waits, then random traffic
    for (int i = 0; i < 170; i++) begin
      run_cycle((i < 13) ? 4'(i) : 4'($urandom_range(12)), (i == 13) ? 20'hf_ffff : 20'($urandom),
                8'($urandom), 1'($urandom), 1'($urandom), (i < 14) ? 4'h0 : 4'($urandom_range(3)));
    end
    for (int i = 0; i < 8; i++) irq_case(3'(i), 3'($urandom), 1'(i == 5));
    irq_case(3'h0, 3'h6, 0);
    i_bus_hold_request_n = 0;
    n = 0;
    do begin @(negedge i_clk); n++; end while (o_bus_hold_grant_n !== 1'b0 && n < 40);
    check("grant", {o_bus_hold_grant_n, o_cyc_ready}, 2'h0);
    irq_case(3'h6, 3'h7, 1);
    i_bus_hold_request_n = 1;
    repeat (12) @(posedge i_clk);
    check("grant released", o_bus_hold_grant_n, 1);
    #1 i_halt_mode = 1;
    repeat (4) @(posedge i_clk);
    check("halt status", {o_cycle_status_out, o_halt_n, o_first_cycle_marker_n}, 3'h0);
    #1 {i_halt_mode, i_sleep_mode} = 2'h1;
    repeat (4) @(posedge i_clk);
    check("sleep status", {o_cycle_status_out, o_halt_n, o_first_cycle_marker_n}, 3'h5);
    #1 {i_sleep_mode, i_dma_request_zero_n, i_dma_edge_mode} = 4'h2;
    repeat (5) @(posedge i_clk);
    check("dma level", o_dma_request[0], 1);
    #1 i_dma_request_one_n = 0;
    n = 0;
    repeat (8) @(posedge i_clk) #1 n += o_dma_request[1];
    check("dma edge", n, 1);
    @(posedge i_clk) #1 n = o_address[18];
    {i_timer_out_select, i_timer_pulse} = {1'b1, n == 0};
    @(posedge i_clk) #1 check("timer pin", {o_address[18], o_address_oe_n[18]}, {n == 0, 1'b0});
    i_timer_out_select = 0;
    @(posedge i_clk) #1 check("address pin", o_address[18], n);
    finish_test();
  end
endmodule // testbench
bind mpu_external_bus_interface bus_if_checker i_chk (.i_clk, .i_rst, .i_cyc_valid,
  .o_cyc_ready, .o_cyc_done, .i_instr_end, .o_take_nmi, .o_take_irq, .o_address,
  .o_address_oe_n, .o_data_oe_n, .o_memory_strobe_n, .o_io_strobe_n, .o_read_strobe_n,
  .o_write_strobe_n, .o_strobe_oe_n, .o_refresh_strobe_n, .o_first_cycle_marker_n,
  .o_cycle_status_out, .o_halt_n, .o_system_clock_out, .o_bus_hold_grant_n);
`default_nettype wire
